// file: logic/phy_irq_pkg.sv
`default_nettype none

package phy_irq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices on the management port
    localparam logic [4:0]  ADDR_PHY_STATUS_TWO      = 5'h11;
    localparam logic [4:0]  ADDR_INTERRUPT_MASK      = 5'h12;
    localparam logic [4:0]  ADDR_EVENT_CHANGE_FLAGS  = 5'h13;

    ////////////////////////////////////////////////////////////////////////////
    // phy_status_two field positions
    localparam int unsigned ST_RATE_100_BIT          = 14;
    localparam int unsigned ST_TX_BUSY_BIT           = 13;
    localparam int unsigned ST_RX_BUSY_BIT           = 12;
    localparam int unsigned ST_COLLISION_BIT         = 11;
    localparam int unsigned ST_LINK_BIT              = 10;
    localparam int unsigned ST_DUPLEX_BIT            = 9;
    localparam int unsigned ST_NEG_MODE_BIT          = 8;
    localparam int unsigned ST_NEG_DONE_BIT          = 7;
    localparam int unsigned ST_POLARITY_BIT          = 5;
    localparam int unsigned ST_PAUSE_BIT             = 4;
    localparam int unsigned ST_ERROR_BIT             = 3;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt_mask field positions and reset value
    localparam int unsigned MSK_NEG_DONE_BIT         = 7;
    localparam int unsigned MSK_RATE_BIT             = 6;
    localparam int unsigned MSK_DUPLEX_BIT           = 5;
    localparam int unsigned MSK_LINK_BIT             = 4;
    localparam int unsigned MSK_GLOBAL_BIT           = 1;
    localparam int unsigned MSK_TEST_BIT             = 0;
    localparam logic [15:0] MASK_RESET               = 16'h0000;
    localparam logic [15:0] MASK_STORED_BITS         = 16'h00f3;

    ////////////////////////////////////////////////////////////////////////////
    // event_change_flags field positions
    localparam int unsigned CHG_NEG_DONE_BIT         = 7;
    localparam int unsigned CHG_RATE_BIT             = 6;
    localparam int unsigned CHG_DUPLEX_BIT           = 5;
    localparam int unsigned CHG_LINK_BIT             = 4;
    localparam int unsigned CHG_PENDING_BIT          = 2;

    ////////////////////////////////////////////////////////////////////////////
    // event vector order used between the internal modules
    localparam int unsigned EV_COUNT                 = 4;
    localparam int unsigned EV_NEG_DONE              = 3;
    localparam int unsigned EV_RATE                  = 2;
    localparam int unsigned EV_DUPLEX                = 1;
    localparam int unsigned EV_LINK                  = 0;
    localparam logic [3:0]  EV_RISE_ONLY             = 4'h8;
    localparam logic [3:0]  EV_RESET                 = 4'h0;
    localparam logic [15:0] RDATA_RESET              = 16'h0000;

endpackage

`default_nettype wire

// file: logic/event_flags_if.sv
`timescale 1ns/1ps
`default_nettype none

interface event_flags_if;
    import phy_irq_pkg::*;

    logic [EV_COUNT-1:0] flags;       // latched change events
    logic [EV_COUNT-1:0] mask;        // per-event enables
    logic                global_en;   // global interrupt enable
    logic                test_force;  // force interrupt for test
    logic                pending;     // interrupt request, active high

    modport detector (output flags);
    modport gen      (input flags, input mask, input global_en, input test_force, output pending);
    modport ctrl     (input flags, input pending, output mask, output global_en, output test_force);
endinterface

`default_nettype wire

// file: logic/change_detect.sv
`timescale 1ns/1ps
`default_nettype none

module change_detect
    import phy_irq_pkg::*;
(
    input  wire logic                clk,       // system clock
    input  wire logic                rst_n,     // synchronous reset, active low
    input  wire logic [EV_COUNT-1:0] level,     // watched status levels
    input  wire logic                clear,     // change register was read
    event_flags_if.detector          ev         // latched events out
);
    logic [EV_COUNT-1:0] prev_q;
    logic                primed_q;
    logic [EV_COUNT-1:0] flag_q;
    logic [EV_COUNT-1:0] hit;

    // the first sample after reset only primes the history, so a link that
    // is already up when reset lifts does not report a change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q   <= EV_RESET;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= level;
            primed_q <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < EV_COUNT; i++) begin : g_ev
            assign hit[i] = primed_q && (EV_RISE_ONLY[i] ? (level[i] && !prev_q[i]) : (level[i] != prev_q[i]));

            // set wins over the read clear so no event is lost
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    flag_q[i] <= 1'b0;
                end else if (hit[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (clear) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign ev.flags = flag_q;
endmodule

`default_nettype wire

// file: logic/irq_gen.sv
`timescale 1ns/1ps
`default_nettype none

module irq_gen
    import phy_irq_pkg::*;
(
    event_flags_if.gen ev  // flags and enables in, request out
);
    logic any_event;

    assign any_event  = |(ev.flags & ev.mask);
    // the test force bypasses the global enable on purpose
    assign ev.pending = (ev.global_en && any_event) || ev.test_force;
endmodule

`default_nettype wire

// file: logic/phy_status_interrupt_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - bit 14 shows 100 Mbps twisted-pair mode
// - bit 13 high while transmitting a packet
// - bit 12 high while receiving a packet
// - bit 11 high during a collision
// - bit 8 shows auto-negotiation mode
// - bit 7 mirrors base negotiation-complete bit
// - bit 5 flags reversed receive polarity
// - bit 4 shows pause capability
// - sticky error bit, cleared by source reads
// - mask bit 7 gates negotiation-done event
// - mask bit 6 gates speed change event
// - mask bit 5 gates duplex change event
// - mask bit 4 gates link change event
// - mask bit 0 forces interrupt for test
// - change bit 7 shows negotiation completed
// - speed change latches, read clears
// - duplex change latches, read clears
// - link change latches, read clears
// - change bit 2 shows interrupt pending
module phy_status_interrupt_regs
    import phy_irq_pkg::*;
(
    input  wire logic        clk,             // system clock, 20 MHz
    input  wire logic        rst_n,           // synchronous reset, active low
    input  wire logic [4:0]  reg_addr,        // management register index
    input  wire logic        reg_wr,          // write strobe, one cycle
    input  wire logic        reg_rd,          // read strobe, one cycle
    input  wire logic [15:0] reg_wdata,       // write data
    output logic      [15:0] reg_rdata,       // read data
    output logic             reg_rvalid,      // read data valid, one cycle
    input  wire logic        rate_100,        // operating 100 Mbps twisted pair
    input  wire logic        tx_busy,         // packet being sent
    input  wire logic        rx_busy,         // packet being received
    input  wire logic        collision,       // collision in progress
    input  wire logic        link_up,         // link state
    input  wire logic        full_duplex,     // resolved duplex
    input  wire logic        neg_mode,        // auto-negotiation enabled
    input  wire logic        neg_complete,    // base status negotiation complete
    input  wire logic        polarity_rev,    // receive polarity reversed
    input  wire logic        pause_capable,   // pause operation capable
    input  wire logic        fault_event,     // remote fault, jabber or parallel detect fault
    input  wire logic        fault_src_read,  // the fault source registers were read
    output logic             mgmt_irq_n       // management interrupt, active low
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] target);
        addr_hit = (addr == target);
    endfunction

    logic hit_status;
    logic hit_mask;
    logic hit_change;

    assign hit_status = addr_hit(reg_addr, ADDR_PHY_STATUS_TWO);
    assign hit_mask   = addr_hit(reg_addr, ADDR_INTERRUPT_MASK);
    assign hit_change = addr_hit(reg_addr, ADDR_EVENT_CHANGE_FLAGS);

    ////////////////////////////////////////////////////////////////////////////
    // internal links between event latching and interrupt generation

    event_flags_if ev ();

    logic [EV_COUNT-1:0] watched;
    logic                change_read;

    assign watched[EV_NEG_DONE] = neg_complete;
    assign watched[EV_RATE]     = rate_100;
    assign watched[EV_DUPLEX]   = full_duplex;
    assign watched[EV_LINK]     = link_up;

    // a read of the change register clears its latched bits
    assign change_read = reg_rd && hit_change;

    change_detect u_change_detect (
        .clk   (clk),
        .rst_n (rst_n),
        .level (watched),
        .clear (change_read),
        .ev    (ev.detector)
    );

    irq_gen u_irq_gen (
        .ev (ev.gen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt mask register

    logic [15:0] mask_q;

    // reserved bits are not stored and read back as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_q <= MASK_RESET;
        end else if (reg_wr && hit_mask) begin
            mask_q <= reg_wdata & MASK_STORED_BITS;
        end
    end

    assign ev.mask[EV_NEG_DONE] = mask_q[MSK_NEG_DONE_BIT];
    assign ev.mask[EV_RATE]     = mask_q[MSK_RATE_BIT];
    assign ev.mask[EV_DUPLEX]   = mask_q[MSK_DUPLEX_BIT];
    assign ev.mask[EV_LINK]     = mask_q[MSK_LINK_BIT];
    assign ev.global_en         = mask_q[MSK_GLOBAL_BIT];
    assign ev.test_force        = mask_q[MSK_TEST_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // sticky error flag

    logic error_q;

    // a fault in the same cycle as the source read keeps the flag set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            error_q <= 1'b0;
        end else if (fault_event) begin
            error_q <= 1'b1;
        end else if (fault_src_read) begin
            error_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read value assembly

    logic [15:0] status_word;
    logic [15:0] change_word;
    logic [15:0] read_word;

    always_comb begin
        status_word                   = RDATA_RESET;
        status_word[ST_RATE_100_BIT]  = rate_100;
        status_word[ST_TX_BUSY_BIT]   = tx_busy;
        status_word[ST_RX_BUSY_BIT]   = rx_busy;
        status_word[ST_COLLISION_BIT] = collision;
        status_word[ST_LINK_BIT]      = link_up;
        status_word[ST_DUPLEX_BIT]    = full_duplex;
        status_word[ST_NEG_MODE_BIT]  = neg_mode;
        // only meaningful while negotiation is enabled; passed through as is
        status_word[ST_NEG_DONE_BIT]  = neg_complete;
        // not valid at 100 Mbps; software must ignore it there
        status_word[ST_POLARITY_BIT]  = polarity_rev;
        status_word[ST_PAUSE_BIT]     = pause_capable;
        status_word[ST_ERROR_BIT]     = error_q;
    end

    always_comb begin
        change_word                   = RDATA_RESET;
        // bit 7 reports the completed state; the latched edge only drives the interrupt
        change_word[CHG_NEG_DONE_BIT] = neg_complete;
        change_word[CHG_RATE_BIT]     = ev.flags[EV_RATE];
        change_word[CHG_DUPLEX_BIT]   = ev.flags[EV_DUPLEX];
        change_word[CHG_LINK_BIT]     = ev.flags[EV_LINK];
        change_word[CHG_PENDING_BIT]  = ev.pending;
    end

    // unmapped indices read as zero
    always_comb begin
        if (hit_status) begin
            read_word = status_word;
        end else if (hit_mask) begin
            read_word = mask_q;
        end else if (hit_change) begin
            read_word = change_word;
        end else begin
            read_word = RDATA_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data port

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= RDATA_RESET;
        end else if (reg_rd) begin
            reg_rdata <= read_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pin

    // registered so the pin never glitches on combinational decode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mgmt_irq_n <= 1'b1;
        end else begin
            mgmt_irq_n <= ~ev.pending;
        end
    end

endmodule

`default_nettype wire

// file: bench/phy_status_interrupt_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module phy_status_interrupt_regs_chk
    import phy_irq_pkg::*;
(
    input wire logic        clk,            // system clock
    input wire logic        rst_n,          // synchronous reset, active low
    input wire logic [4:0]  reg_addr,       // register index
    input wire logic        reg_wr,         // write strobe
    input wire logic        reg_rd,         // read strobe
    input wire logic [15:0] reg_wdata,      // write data
    input wire logic [15:0] reg_rdata,      // read data
    input wire logic        reg_rvalid,     // read data valid
    input wire logic        rate_100,       // 100 Mbps mode
    input wire logic        tx_busy,        // sending
    input wire logic        rx_busy,        // receiving
    input wire logic        collision,      // collision
    input wire logic        link_up,        // link state
    input wire logic        full_duplex,    // duplex
    input wire logic        neg_mode,       // negotiation mode
    input wire logic        neg_complete,   // negotiation complete
    input wire logic        polarity_rev,   // polarity reversed
    input wire logic        pause_capable,  // pause capable
    input wire logic        fault_event,    // fault
    input wire logic        fault_src_read, // fault source read
    input wire logic        mgmt_irq_n      // interrupt, active low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // shadow of the stored mask bits, so gating can be judged from port traffic
    logic [15:0] mask_q;
    always_ff @(posedge clk) begin
        if (!rst_n) mask_q <= MASK_RESET;
        else if (reg_wr && reg_addr == ADDR_INTERRUPT_MASK) mask_q <= reg_wdata & MASK_STORED_BITS;
    end

    sequence s_rd_st;
        reg_rd && reg_addr == ADDR_PHY_STATUS_TWO;
    endsequence
    sequence s_rd_chg;
        reg_rd && reg_addr == ADDR_EVENT_CHANGE_FLAGS;
    endsequence
    sequence s_lv_quiet;
        $stable({rate_100, full_duplex, link_up, neg_complete});
    endsequence
    sequence s_quiet_read;
        (s_rd_chg and s_lv_quiet and !mask_q[0]) ##1 s_lv_quiet;
    endsequence
    // history of the edge detector is primed one edge after release
    property p_raise(lv, m);
        $past(rst_n) && $past(rst_n, 2) && !reg_wr && lv && m && mask_q[MSK_GLOBAL_BIT] |-> ##2 !mgmt_irq_n;
    endproperty

    chk_read_answer:  assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    chk_rate_bit:     assert property (s_rd_st |=> reg_rdata[14] == $past(rate_100)) else $error("rate bit");
    chk_activity:     assert property (s_rd_st |=> reg_rdata[13:11] == $past({tx_busy, rx_busy, collision}))
        else $error("activity bits");
    chk_link_duplex:  assert property (s_rd_st |=> reg_rdata[10:9] == $past({link_up, full_duplex}))
        else $error("link or duplex bit");
    chk_neg_bits:     assert property (s_rd_st |=> reg_rdata[8:7] == $past({neg_mode, neg_complete}))
        else $error("negotiation bits");
    chk_pol_pause:    assert property (s_rd_st |=> reg_rdata[5:4] == $past({polarity_rev, pause_capable}))
        else $error("polarity or pause bit");
    chk_done_live:    assert property (s_rd_chg |=> reg_rdata[7] == $past(neg_complete))
        else $error("done bit");
    chk_pending_bit:  assert property (s_rd_chg |=> reg_rdata[2] == !mgmt_irq_n) else $error("pending bit");
    chk_test_force:   assert property (mask_q[0] |=> !mgmt_irq_n) else $error("test force ignored");
    chk_global_off:   assert property (!mask_q[1] && !mask_q[0] |=> mgmt_irq_n)
        else $error("irq while off");
    chk_read_release: assert property (s_quiet_read |=> mgmt_irq_n) else $error("irq not released");
    chk_link_raise:   assert property (p_raise($changed(link_up), mask_q[4])) else $error("link irq");
    chk_duplex_raise: assert property (p_raise($changed(full_duplex), mask_q[5])) else $error("duplex irq");
    chk_rate_raise:   assert property (p_raise($changed(rate_100), mask_q[6])) else $error("rate irq");
    chk_done_raise:   assert property (p_raise($rose(neg_complete), mask_q[7])) else $error("done irq");
endmodule

bind phy_status_interrupt_regs phy_status_interrupt_regs_chk u_chk (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rate_100(rate_100), .tx_busy(tx_busy), .rx_busy(rx_busy),
    .collision(collision), .link_up(link_up), .full_duplex(full_duplex), .neg_mode(neg_mode),
    .neg_complete(neg_complete), .polarity_rev(polarity_rev), .pause_capable(pause_capable),
    .fault_event(fault_event), .fault_src_read(fault_src_read), .mgmt_irq_n(mgmt_irq_n));

`default_nettype wire

// file: bench/mgmt_station.sv
`timescale 1ns/1ps
`default_nettype none

module mgmt_station (
    input  wire logic        clk,        // system clock
    input  wire logic [15:0] reg_rdata,  // read data
    input  wire logic        reg_rvalid, // read data valid
    output logic      [4:0]  reg_addr,   // register index
    output logic             reg_wr,     // write strobe
    output logic             reg_rd,     // read strobe
    output logic      [15:0] reg_wdata   // write data
);
    initial begin
        reg_addr  = 5'h00;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_wdata = 16'h0000;
    end

    // called at a falling edge; strobe spans exactly one rising edge, then an
    // idle cycle so back-to-back calls never re-drive the strobe in one step
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'h1;
        @(negedge clk);
        reg_wr    = 1'h0;
        reg_wdata = ~v;
        @(negedge clk);
    endtask

    // a missing valid turns the word unknown so any compare fails
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        reg_addr = a;
        reg_rd   = 1'h1;
        @(negedge clk);
        reg_rd   = 1'h0;
        reg_addr = ~a;
        v        = (reg_rvalid === 1'h1) ? reg_rdata : 16'hxxxx;
        @(negedge clk);
    endtask
endmodule

`default_nettype wire

// file: bench/phy_status_interrupt_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module phy_status_interrupt_regs_test;
    import phy_irq_pkg::*;

    logic        clk, rst_n, fault_event, fault_src_read, reg_wr, reg_rd, reg_rvalid, mgmt_irq_n, en;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, lf, d;
    logic [9:0]  st;
    int          errors, n_compared;
    int          pos[4] = '{5, 4, 9, 2};
    int          mb[4]  = '{4, 5, 6, 7};

    phy_status_interrupt_regs i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .rate_100(st[9]), .tx_busy(st[8]), .rx_busy(st[7]), .collision(st[6]), .link_up(st[5]),
        .full_duplex(st[4]), .neg_mode(st[3]), .neg_complete(st[2]), .polarity_rev(st[1]),
        .pause_capable(st[0]), .fault_event(fault_event), .fault_src_read(fault_src_read),
        .mgmt_irq_n(mgmt_irq_n));
    mgmt_station i_mgmt (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_status(input logic [9:0] s, input logic e);
        return {1'h0, s[9:2], 1'h0, s[1:0], e, 3'h0};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // the whole sequence needs under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        {rst_n, fault_event, fault_src_read, st, errors, n_compared, lf} = {3'h0, 10'h000, 64'h0, 16'h0a17};
        repeat (10) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check(mgmt_irq_n, 1'h1);
        i_mgmt.rd(ADDR_INTERRUPT_MASK, d);
        check(d, MASK_RESET);
        i_mgmt.rd(5'h1f, d);
        check(d, 16'h0000);
        i_mgmt.wr(ADDR_INTERRUPT_MASK, 16'hff0c);
        i_mgmt.wr(ADDR_PHY_STATUS_TWO, 16'hffff);
        i_mgmt.rd(ADDR_INTERRUPT_MASK, d);
        check(d, 16'h0000);
        for (int k = 0; k < 12; k++) begin
            lf = lfsr(lf);
            st = (k == 0) ? 10'h3ff : lf[9:0];
            i_mgmt.rd(ADDR_PHY_STATUS_TWO, d);
            check(d & 16'hfc00, exp_status(st, 1'h0) & 16'hfc00);
            check(d & 16'h03ff, exp_status(st, 1'h0) & 16'h03ff);
        end
        fault_event = 1'h1;
        @(negedge clk);
        fault_event = 1'h0;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) fault_src_read = 1'h1;
            @(negedge clk);
            fault_src_read = 1'h0;
            i_mgmt.rd(ADDR_PHY_STATUS_TWO, d);
            check(d[3], k < 2);
        end
        // fault and source read in one cycle: the fault must win
        {fault_event, fault_src_read} = 2'h3;
        @(negedge clk);
        {fault_event, fault_src_read} = 2'h0;
        i_mgmt.rd(ADDR_PHY_STATUS_TWO, d);
        check(d[3], 1'h1);
        st = 10'h000;
        repeat (2) @(negedge clk);
        i_mgmt.rd(ADDR_EVENT_CHANGE_FLAGS, d);
        i_mgmt.rd(ADDR_EVENT_CHANGE_FLAGS, d);
        check(d, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            for (int e = 1; e >= 0; e--) begin
                en = e[0];
                i_mgmt.wr(ADDR_INTERRUPT_MASK, en ? 16'h0002 | (16'h0001 << mb[i]) : 16'h00f2 ^ (16'h0001 << mb[i]));
                st[pos[i]] = ~st[pos[i]];
                repeat (3) @(negedge clk);
                check(mgmt_irq_n, !en);
                i_mgmt.rd(ADDR_EVENT_CHANGE_FLAGS, d);
                check(d[mb[i]], i == 3 ? st[2] : 1'h1);
                check(d[2], en);
                repeat (2) @(negedge clk);
                check(mgmt_irq_n, 1'h1);
            end
        end
        i_mgmt.wr(ADDR_INTERRUPT_MASK, 16'h00f0);
        st[5] = ~st[5];
        repeat (3) @(negedge clk);
        check(mgmt_irq_n, 1'h1);
        i_mgmt.rd(ADDR_EVENT_CHANGE_FLAGS, d);
        check(d[4], 1'h1);
        i_mgmt.wr(ADDR_INTERRUPT_MASK, 16'h0001);
        repeat (2) @(negedge clk);
        check(mgmt_irq_n, 1'h0);
        i_mgmt.rd(ADDR_EVENT_CHANGE_FLAGS, d);
        check(d[2], 1'h1);
        i_mgmt.wr(ADDR_INTERRUPT_MASK, 16'h0000);
        repeat (2) @(negedge clk);
        check(mgmt_irq_n, 1'h1);
        i_mgmt.wr(ADDR_INTERRUPT_MASK, 16'hffff);
        i_mgmt.rd(ADDR_INTERRUPT_MASK, d);
        check(d, MASK_STORED_BITS);
        check(mgmt_irq_n, 1'h0);
        // mid-run reset with the link up: levels present at release must not count as changes
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check(mgmt_irq_n, 1'h1);
        i_mgmt.rd(ADDR_INTERRUPT_MASK, d);
        check(d, MASK_RESET);
        i_mgmt.rd(ADDR_EVENT_CHANGE_FLAGS, d);
        check(d & 16'h0074, 16'h0000);
        give_verdict();
    end
endmodule

`default_nettype wire
